// ==== logic/probe_detect.sv ====
// module: debug probe presence detector with access level gating
// -------------------------------------------------------------------
// Summary of operation
// - cold-plug flagged on reset extension during reset
// - hot-plug detector held cleared during any reset
// - hot-plug registered on serial clock falling edge
// - pad reassigned disables hot-plug until reset
// - readable bit shows hot-plug availability
// - either detection sets debugger present bit
// - locked access level suppresses hot-plug detection
// - detection inactive until power-on reset released
// - full level unrestricted, locked level boot only
// - level two secure, level one non-secure only
// -------------------------------------------------------------------
`default_nettype none
module probe_detect (
  // clock and power-on reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  // pins from the probe side
  input  wire logic        SWCLK_I,
  input  wire logic        EXT_RSTN_I,
  // reset controller and fuses
  input  wire logic        CPU_RST_EXT_REQ_I,
  input  wire logic [1:0]  DEBUG_ACCESS_LEVEL_I,
  // register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  // results
  output logic             HOT_PLUG_AVAILABLE_O,
  output logic             DEBUGGER_PRESENT_O,
  output logic [1:0]       PAD_FUNC_O,
  output logic             ACCESS_FULL_O,
  output logic             ACCESS_NONSECURE_O,
  output logic             ACCESS_BOOTROM_ONLY_O,
  output logic             IRQ_O
);

  // -----------------------------------------------------------------
  // pin synchronisation
  // -----------------------------------------------------------------
  logic [1:0] pins_s;
  logic       swclk_s;
  logic       in_reset;

  // external reset starts asserted so no edge leaks before it settles
  pin_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'h1)
  ) u_pin_sync (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RSTN_I),
    .async_i ({EXT_RSTN_I, SWCLK_I}),
    .sync_o  (pins_s)
  );

  assign swclk_s  = pins_s[0];
  assign in_reset = ~pins_s[1];

  // -----------------------------------------------------------------
  // registers and state
  // -----------------------------------------------------------------
  probe_detect_pkg::hp_state_e     hp_state_reg;
  probe_detect_pkg::hp_state_e     hp_state_next;
  logic                            sw_prev_reg;
  logic                            sw_prev_next;
  logic                            present_reg;
  logic                            present_next;
  logic [1:0]                      pad_reg;
  logic [1:0]                      pad_next;
  logic [31:0]                     rdata_reg;
  logic [31:0]                     rdata_next;
  probe_detect_pkg::access_grant_s grant_reg;
  probe_detect_pkg::access_grant_s grant_next;
  probe_detect_pkg::detect_evt_s   evt;
  logic                            sw_fall;
  logic                            pad_moved;
  logic                            level_locked;
  logic                            hp_avail;
  logic [2:0]                      irq_sts;
  logic [2:0]                      irq_en;

  // decode of the access level into grants
  function automatic probe_detect_pkg::access_grant_s grant_of(input logic [1:0] level);
    probe_detect_pkg::access_grant_s g;
    g = '0;
    if (level == probe_detect_pkg::access_level_full)
      g.full = 1'b1;
    else if (level == probe_detect_pkg::access_level_nonsecure)
      g.nonsecure = 1'b1;
    else
      g.bootrom_only = 1'b1;
    return g;
  endfunction

  // -----------------------------------------------------------------
  // detection logic
  // -----------------------------------------------------------------
  // only code 0 stops hot-plug; code 3 is boot-only in the grants,
  // which keeps an unknown fuse value on the safe side for memory access
  assign level_locked = (DEBUG_ACCESS_LEVEL_I == probe_detect_pkg::access_level_locked);
  assign pad_moved  = (pad_reg != probe_detect_pkg::PAD_FUNC_DEBUG);
  assign sw_fall    = sw_prev_reg & ~swclk_s;
  assign hp_avail   = (hp_state_reg == probe_detect_pkg::HP_ARMED);

  // detection events of this cycle
  always_comb
  begin
    evt      = '0;
    evt.cold = in_reset & CPU_RST_EXT_REQ_I;
    evt.hot  = hp_avail & sw_fall & ~in_reset
             & ~pad_moved & ~level_locked;
    evt.hp_lost = hp_avail & ~in_reset & (pad_moved | level_locked);
  end

  // hot-plug detector, cleared by reset, locked by pad or level
  always_comb
  begin
    hp_state_next = hp_state_reg;
    sw_prev_next  = swclk_s;
    unique case (hp_state_reg)
      probe_detect_pkg::HP_HELD:
      begin
        if (!in_reset)
          hp_state_next = (pad_moved | level_locked) ? probe_detect_pkg::HP_LOCKED
                                                   : probe_detect_pkg::HP_ARMED;
      end
      probe_detect_pkg::HP_ARMED:
      begin
        if (in_reset)
          hp_state_next = probe_detect_pkg::HP_HELD;
        else if (pad_moved | level_locked)
          hp_state_next = probe_detect_pkg::HP_LOCKED;
      end
      probe_detect_pkg::HP_LOCKED:
      begin
        if (in_reset)
          hp_state_next = probe_detect_pkg::HP_HELD;
      end
      default:
        hp_state_next = probe_detect_pkg::HP_HELD;
    endcase
  end

  // debugger present is sticky until power-on reset only, so a
  // cold-plug caught during external reset outlives that reset
  always_comb
  begin
    present_next = present_reg | evt.cold | evt.hot;
    grant_next   = grant_of(DEBUG_ACCESS_LEVEL_I);
  end

  // pad function: external reset restores the debug function
  always_comb
  begin
    pad_next = pad_reg;
    if (in_reset)
      pad_next = probe_detect_pkg::PAD_FUNC_DEBUG;
    else if (WR_I && ADDR_I == probe_detect_pkg::OFS_CONTROL)
      pad_next = WDATA_I[probe_detect_pkg::CTL_PAD_LSB +: probe_detect_pkg::PAD_W];
  end

  // -----------------------------------------------------------------
  // register read path
  // -----------------------------------------------------------------
  // read data lives for one cycle after the strobe, zero otherwise
  always_comb
  begin
    rdata_next = '0;
    if (RD_I)
    begin
      unique case (ADDR_I)
        probe_detect_pkg::OFS_STATUS:
        begin
          rdata_next[probe_detect_pkg::STS_HP_AVAIL_BIT] = hp_avail;
          rdata_next[probe_detect_pkg::STS_PRESENT_BIT]  = present_reg;
          rdata_next[probe_detect_pkg::STS_IN_RESET_BIT] = in_reset;
        end
        probe_detect_pkg::OFS_CONTROL:
          rdata_next[probe_detect_pkg::CTL_PAD_LSB +: probe_detect_pkg::PAD_W] = pad_reg;
        probe_detect_pkg::OFS_IRQ_STATUS:
          rdata_next[probe_detect_pkg::EVT_W-1:0] = irq_sts;
        probe_detect_pkg::OFS_IRQ_ENABLE:
          rdata_next[probe_detect_pkg::EVT_W-1:0] = irq_en;
        default:
          rdata_next = '0;
      endcase
    end
  end

  // power-on reset clears everything here except sw_prev_reg, which it sets high; external reset also resets the detector state and pad
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      hp_state_reg <= probe_detect_pkg::HP_HELD;
      sw_prev_reg  <= 1'b1;
      present_reg  <= probe_detect_pkg::PRESENT_RESET;
      pad_reg      <= probe_detect_pkg::PAD_FUNC_DEBUG;
      rdata_reg    <= '0;
      grant_reg    <= '0;
    end
    else
    begin
      hp_state_reg <= hp_state_next;
      sw_prev_reg  <= sw_prev_next;
      present_reg  <= present_next;
      pad_reg      <= pad_next;
      rdata_reg    <= rdata_next;
      grant_reg    <= grant_next;
    end
  end

  // -----------------------------------------------------------------
  // interrupt status
  // -----------------------------------------------------------------
  irq_status u_irq (
    .clk_i    (SYS_CLK_I),
    .rstn_i   (RSTN_I),
    .evt_i    (evt),
    .clr_wr_i (WR_I && ADDR_I == probe_detect_pkg::OFS_IRQ_CLEAR),
    .en_wr_i  (WR_I && ADDR_I == probe_detect_pkg::OFS_IRQ_ENABLE),
    .wdata_i  (WDATA_I[probe_detect_pkg::EVT_W-1:0]),
    .status_o (irq_sts),
    .enable_o (irq_en),
    .irq_o    (IRQ_O)
  );

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign RDATA_O               = rdata_reg;
  assign HOT_PLUG_AVAILABLE_O  = hp_avail;
  assign DEBUGGER_PRESENT_O    = present_reg;
  assign PAD_FUNC_O            = pad_reg;
  assign ACCESS_FULL_O         = grant_reg.full;
  assign ACCESS_NONSECURE_O    = grant_reg.nonsecure;
  assign ACCESS_BOOTROM_ONLY_O = grant_reg.bootrom_only;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking chk_cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  cold_flag_a: assert property (in_reset && CPU_RST_EXT_REQ_I |=> DEBUGGER_PRESENT_O)
    else $error("cold-plug did not set present");
  reset_hold_a: assert property (in_reset |=> !HOT_PLUG_AVAILABLE_O && !evt.hot)
    else $error("hot-plug active during reset");
  // checks read synchronised pin levels only, never the raw pads
  hot_edge_a: assert property (
    hp_avail && !in_reset && !pad_moved && !level_locked && $past(swclk_s) && !swclk_s
    |=> DEBUGGER_PRESENT_O)
    else $error("falling edge not registered");
  pad_lock_a: assert property (pad_moved && !in_reset |=> !HOT_PLUG_AVAILABLE_O [*2])
    else $error("hot-plug available with pad moved");
  pad_restore_a: assert property (
    in_reset |=> PAD_FUNC_O == probe_detect_pkg::PAD_FUNC_DEBUG)
    else $error("pad function not restored in reset");
  avail_return_a: assert property (
    hp_state_reg == probe_detect_pkg::HP_HELD && !in_reset && !pad_moved && !level_locked
    |=> HOT_PLUG_AVAILABLE_O)
    else $error("detector not available after reset");
  avail_bit_a: assert property (RD_I && ADDR_I == probe_detect_pkg::OFS_STATUS
    |=> RDATA_O[probe_detect_pkg::STS_HP_AVAIL_BIT] == $past(HOT_PLUG_AVAILABLE_O))
    else $error("status bit differs from availability");
  avail_drop_a: assert property (
    HOT_PLUG_AVAILABLE_O && !in_reset && (pad_moved || level_locked)
    |=> !HOT_PLUG_AVAILABLE_O && irq_sts[2])
    else $error("availability not withdrawn");
  present_sticky_a: assert property (DEBUGGER_PRESENT_O |=> DEBUGGER_PRESENT_O)
    else $error("present flag dropped");
  present_cause_a: assert property (
    $rose(DEBUGGER_PRESENT_O) |-> $past(evt.cold || evt.hot))
    else $error("present flag set without detection");
  locked_level_a: assert property (level_locked |-> !evt.hot ##1 !HOT_PLUG_AVAILABLE_O)
    else $error("hot-plug at locked level");
  grant_map_a: assert property (
    ##1 $past(DEBUG_ACCESS_LEVEL_I) == probe_detect_pkg::access_level_nonsecure
    |-> ACCESS_NONSECURE_O && !ACCESS_FULL_O)
    else $error("non-secure grant wrong");
  locked_grant_a: assert property (
    level_locked |=> ACCESS_BOOTROM_ONLY_O && !ACCESS_FULL_O)
    else $error("locked level granted access");
  full_grant_a: assert property (
    DEBUG_ACCESS_LEVEL_I == probe_detect_pkg::access_level_full
    |=> ACCESS_FULL_O && !ACCESS_NONSECURE_O && !ACCESS_BOOTROM_ONLY_O)
    else $error("full level grant wrong");
  sync_edge_a: assert property (evt.hot |-> $past(swclk_s, 1) && !swclk_s)
    else $error("edge seen without synchronised fall");
  state_onehot_a: assert property ($onehot(hp_state_reg))
    else $error("detector state not one-hot");

endmodule
`default_nettype wire

// ==== logic/probe_detect_pkg.sv ====
// package: register map, field layout and codes of the probe presence detector
`default_nettype none
package probe_detect_pkg;

  // -----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // -----------------------------------------------------------------
  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 32;
  localparam logic [7:0] OFS_STATUS      = 8'h00;
  localparam logic [7:0] OFS_CONTROL     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h10;

  // -----------------------------------------------------------------
  // field positions and reset values
  // -----------------------------------------------------------------
  localparam int         STS_HP_AVAIL_BIT = 0;
  localparam int         STS_PRESENT_BIT  = 1;
  localparam int         STS_IN_RESET_BIT = 2;
  localparam int         CTL_PAD_LSB      = 0;
  localparam int         PAD_W            = 2;
  localparam logic [1:0] PAD_FUNC_DEBUG   = 2'h0;
  localparam int         EVT_W            = 3;
  localparam logic [2:0] IRQ_EN_RESET     = 3'h0;
  localparam logic       PRESENT_RESET    = 1'b0;

  // -----------------------------------------------------------------
  // debug access level codes
  // -----------------------------------------------------------------
  localparam logic [1:0] access_level_locked    = 2'h0;
  localparam logic [1:0] access_level_nonsecure = 2'h1;
  localparam logic [1:0] access_level_full      = 2'h2;

  // detection events, bit order equals interrupt bit order
  typedef struct packed {
    logic hp_lost;
    logic hot;
    logic cold;
  } detect_evt_s;

  // access granted to the probe
  typedef struct packed {
    logic full;
    logic nonsecure;
    logic bootrom_only;
  } access_grant_s;

  // hot-plug detector states
  typedef enum logic [2:0] {
    HP_HELD   = 3'h1,
    HP_ARMED  = 3'h2,
    HP_LOCKED = 3'h4
  } hp_state_e;

endpackage
`default_nettype wire

// ==== logic/pin_sync.sv ====
// module: two-stage synchroniser for asynchronous pin levels
`default_nettype none
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage is read only by the second stage
  always_comb
  begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule
`default_nettype wire

// ==== logic/irq_status.sv ====
// module: sticky event status, write-one-to-clear and enable mask
`default_nettype none
module irq_status (
  // clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rstn_i,
  // events from the detector
  input  wire probe_detect_pkg::detect_evt_s    evt_i,
  // software access
  input  wire logic                             clr_wr_i,
  input  wire logic                             en_wr_i,
  input  wire logic [probe_detect_pkg::EVT_W-1:0] wdata_i,
  // state
  output logic      [probe_detect_pkg::EVT_W-1:0] status_o,
  output logic      [probe_detect_pkg::EVT_W-1:0] enable_o,
  output logic                                  irq_o
);

  logic [probe_detect_pkg::EVT_W-1:0] status_reg;
  logic [probe_detect_pkg::EVT_W-1:0] status_next;
  logic [probe_detect_pkg::EVT_W-1:0] enable_reg;
  logic [probe_detect_pkg::EVT_W-1:0] enable_next;

  // set wins over clear so an event in the clearing cycle survives
  always_comb
  begin
    status_next = status_reg;
    if (clr_wr_i)
      status_next = status_reg & ~wdata_i;
    status_next = status_next | evt_i;
    enable_next = en_wr_i ? wdata_i : enable_reg;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      status_reg <= '0;
      enable_reg <= probe_detect_pkg::IRQ_EN_RESET;
    end
    else
    begin
      status_reg <= status_next;
      enable_reg <= enable_next;
    end
  end

  assign status_o = status_reg;
  assign enable_o = enable_reg;
  assign irq_o    = |(status_reg & enable_reg);

endmodule
`default_nettype wire

// ==== test/probe_model.sv ====
// model: serial-wire debug probe driving clock and external reset pins
`default_nettype none
module probe_model (
  // pins towards the device
  output logic swclk_o,
  output logic ext_rstn_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // both pins idle high: clock stands still between frames, reset has a pull-up
  initial
  begin
    swclk_o    = 1'b1;
    ext_rstn_o = 1'b1;
  end

  // one frame of clock pulses, 80 ns period, phase unrelated to the system clock
  task automatic burst(input int n);
    repeat (n)
    begin
      #40.3 swclk_o = 1'b0;
      #39.7 swclk_o = 1'b1;
    end
  endtask

  // hold external reset; probe keeps it beyond power-on reset when locked
  task automatic hold_reset();
    #3.1 ext_rstn_o = 1'b0;
  endtask

  // release external reset after the connect attempt
  task automatic release_reset();
    #3.1 ext_rstn_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== test/probe_detect_bench.sv ====
// bench: self-checking testbench of the probe presence detector
`default_nettype none
module probe_detect_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // stimulus and observation signals
  // ---------------------------------------------------------------
  logic        clk   = 1'b0;
  logic        rstn  = 1'b0;
  logic        req   = 1'b0;
  logic [1:0]  level = 2'h2;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        rd_d  = 1'b0;
  logic [31:0] rdata;
  logic        hp_avail;
  logic        present;
  logic [1:0]  pad;
  logic        acc_full;
  logic        acc_ns;
  logic        acc_boot;
  logic        irq;
  wire         swclk;
  wire         ext_rstn;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h0001_40A0;
  int          failures = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  probe_model partner_u (.swclk_o(swclk), .ext_rstn_o(ext_rstn));

  probe_detect dut_u (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .SWCLK_I(swclk), .EXT_RSTN_I(ext_rstn),
    .CPU_RST_EXT_REQ_I(req), .DEBUG_ACCESS_LEVEL_I(level),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .HOT_PLUG_AVAILABLE_O(hp_avail), .DEBUGGER_PRESENT_O(present), .PAD_FUNC_O(pad),
    .ACCESS_FULL_O(acc_full), .ACCESS_NONSECURE_O(acc_ns),
    .ACCESS_BOOTROM_ONLY_O(acc_boot), .IRQ_O(irq)
  );

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // read data stands only in the cycle after the strobe, so sample mid-cycle
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk)
    if (rd_d)
    begin
      if (exp_q.size() == 0)
        chk(rdata, 32'hDEAD_BEEF);
      else
        chk(rdata, exp_q.pop_front());
    end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ---------------------------------------------------------------
  // bus cycles, one idle edge between strobes
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    int i;
    // power-on reset, outputs quiet throughout
    cyc(4);
    chk({30'h0, hp_avail, present}, 32'h0);
    cyc(1);
    rstn <= 1'b1;
    cyc(8);
    rd_reg(probe_detect_pkg::OFS_STATUS, 32'h1);
    rd_reg(probe_detect_pkg::OFS_IRQ_ENABLE, 32'h0);
    rd_reg(8'h40, 32'h0);
    rd_reg(probe_detect_pkg::OFS_IRQ_CLEAR, 32'h0);
    // random enable pattern, then all sources enabled
    seed = lfsr(seed);
    wr_reg(probe_detect_pkg::OFS_IRQ_ENABLE, seed);
    rd_reg(probe_detect_pkg::OFS_IRQ_ENABLE, {29'h0, seed[2:0]});
    wr_reg(probe_detect_pkg::OFS_IRQ_ENABLE, 32'h7);
    // hot plug while running at full level
    partner_u.burst(3);
    cyc(6);
    rd_reg(probe_detect_pkg::OFS_STATUS, 32'h3);
    rd_reg(probe_detect_pkg::OFS_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr_reg(probe_detect_pkg::OFS_IRQ_CLEAR, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    // pad moved away: detector disabled until reset
    wr_reg(probe_detect_pkg::OFS_CONTROL, 32'h1);
    cyc(2);
    chk({30'h0, pad}, 32'h1);
    rd_reg(probe_detect_pkg::OFS_STATUS, 32'h2);
    rd_reg(probe_detect_pkg::OFS_IRQ_STATUS, 32'h4);
    wr_reg(probe_detect_pkg::OFS_IRQ_CLEAR, 32'h4);
    partner_u.burst(3);
    cyc(6);
    rd_reg(probe_detect_pkg::OFS_IRQ_STATUS, 32'h0);
    // external reset: no hot plug, cold plug on extension request
    partner_u.hold_reset();
    cyc(4);
    rd_reg(probe_detect_pkg::OFS_STATUS, 32'h6);
    chk({30'h0, pad}, 32'h0);
    wr_reg(probe_detect_pkg::OFS_CONTROL, 32'h1);
    partner_u.burst(3);
    cyc(6);
    req <= 1'b1;
    cyc(2);
    req <= 1'b0;
    rd_reg(probe_detect_pkg::OFS_IRQ_STATUS, 32'h1);
    rd_reg(probe_detect_pkg::OFS_CONTROL, 32'h0);
    partner_u.release_reset();
    cyc(8);
    rd_reg(probe_detect_pkg::OFS_STATUS, 32'h3);
    // access decode for every level code
    for (i = 0; i < 4; i++)
    begin
      level <= i[1:0];
      cyc(3);
      chk({29'h0, acc_full, acc_ns, acc_boot}, {29'h0, i == 2, i == 1, i[0] == i[1]});
    end
    level <= probe_detect_pkg::access_level_locked;
    cyc(3);
    chk({31'h0, hp_avail}, 32'h0);
    wr_reg(probe_detect_pkg::OFS_IRQ_CLEAR, 32'h7);
    partner_u.burst(3);
    cyc(6);
    rd_reg(probe_detect_pkg::OFS_IRQ_STATUS, 32'h0);
    // locked cold start, first try lets go of external reset too early
    rstn <= 1'b0;
    req  <= 1'b1;
    partner_u.hold_reset();
    cyc(3);
    req <= 1'b0;
    partner_u.release_reset();
    cyc(2);
    rstn <= 1'b1;
    cyc(6);
    chk({31'h0, present}, 32'h0);
    // retry: probe holds external reset past power-on reset this time
    rstn <= 1'b0;
    req  <= 1'b1;
    partner_u.hold_reset();
    cyc(5);
    chk({31'h0, present}, 32'h0);
    rstn <= 1'b1;
    i = 0;
    while (present !== 1'b1 && i < 20)
    begin
      cyc(1);
      i++;
    end
    chk({31'h0, present}, 32'h1);
    req <= 1'b0;
    partner_u.release_reset();
    cyc(4);
    close_out();
  end
endmodule
`default_nettype wire
